// [design/vic_pkg.sv]
// Function
// - merge all requests into one CPU request
// - seven user priority levels per source
// - fixed order breaks equal priority ties
// - lower vector number wins the tie
// - entry and return take fixed cycles
// - primary table at 000004h, traps plus sources
// - fetched 24-bit entry is the handler address
// - alternate table needs segment, fuse, enable
// - alternate table replaces primary for all
// - alternate base is last boot page start
// - table fetches carry boot segment protection
// - reset clears state, starts at zero
// - CPU level is extension bit over status
// - secondary event match at vector 81
// - serial3 done sources at vectors 98, 99
// - PWM generators at vectors 102 to 109
// - comparators 111-113, analog 118-125
// - 3-bit priority fields, four per register
// - flag and enable pairs, sixteen per word
package vic_pkg;
   // request and trap counts
   localparam int unsigned NUM_IRQ   = 128;
   localparam int unsigned NUM_TRAP  = 6;
   localparam logic [7:0]  VECTOR_OFFSET = 8'h08;   // vector minus request
   // implemented sources, one 16-bit word per flag word 4..7
   localparam logic [15:0] IMPL_W4 = 16'h0200;
   localparam logic [15:0] IMPL_W5 = 16'hCC00;
   localparam logic [15:0] IMPL_W6 = 16'hC3BF;
   localparam logic [15:0] IMPL_W7 = 16'h003F;
   localparam logic [NUM_IRQ-1:0] IMPL_MASK =
      {IMPL_W7, IMPL_W6, IMPL_W5, IMPL_W4, 64'h0000000000000000};
   // register offsets
   localparam logic [11:0] CTRL_OFFSET   = 12'h000;
   localparam logic [11:0] STATUS_OFFSET = 12'h004;
   localparam logic [11:0] TRAP_OFFSET   = 12'h008;
   localparam logic [11:0] FLAG_BASE     = 12'h100;
   localparam logic [11:0] ENABLE_BASE   = 12'h140;
   localparam logic [11:0] PRIO_BASE     = 12'h200;
   // field positions
   localparam int unsigned ALT_EN_BIT     = 8;
   localparam int unsigned STAT_VEC_LSB   = 0;
   localparam int unsigned STAT_STATE_LSB = 8;
   localparam int unsigned STAT_LEVEL_LSB = 10;
   localparam int unsigned PAGE_SHIFT     = 11;
   // addresses and counts
   localparam logic [23:0] PRIMARY_BASE  = 24'h000004;
   localparam logic [23:0] RESET_ADDR    = 24'h000000;
   localparam logic [1:0]  FETCH_CYCLES  = 2'h2;
   localparam logic [1:0]  RETURN_CYCLES = 2'h3;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   // controller states, gray along idle-fetch-present
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_FETCH   = 2'b01,
      ST_PRESENT = 2'b11,
      ST_RETURN  = 2'b10
   } state_t;
   // register classes of a bus address
   typedef enum logic [2:0] {
      CLS_NONE, CLS_CTRL, CLS_STATUS, CLS_TRAP,
      CLS_FLAG, CLS_ENABLE, CLS_PRIO
   } reg_class_t;
endpackage

// [design/vectored_interrupt_controller.sv]
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_controller (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address
   input  wire logic [11:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   // axi4-lite write data
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   // axi4-lite write response
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // axi4-lite read
   input  wire logic [11:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // peripheral events and traps
   input  wire logic [127:0] irq_set,
   input  wire logic [5:0]   trap_req,
   // configuration words
   input  wire logic [12:0] boot_segment_limit,
   input  wire logic        alt_table_disable_fuse,
   // cpu core side
   input  wire logic [7:0]  cpu_status_register,
   input  wire logic        priority_level_extension,
   input  wire logic        cpu_irq_ack,
   input  wire logic        cpu_return,
   output logic             cpu_irq_req,
   output logic [7:0]       cpu_vector,
   output logic [23:0]      cpu_handler_addr,
   output logic             cpu_ret_done,
   output logic             cpu_reset_start,
   // program memory vector fetch
   output logic             pm_rd,
   output logic [23:0]      pm_addr,
   output logic             pm_boot_access,
   input  wire logic [23:0] pm_rdata
);

   // source storage, only implemented bits ever change
   logic [127:0]        flag_reg;         // pending flags
   logic [127:0]        enable_reg;       // enables
   logic [383:0]        prio_reg;         // 3 bits per source
   logic [5:0]          trap_flag_reg;    // sticky traps
   logic                alt_table_enable_reg;
   // write channel holding
   logic [11:0]         aw_addr_reg;
   logic [31:0]         wdata_reg;
   logic [3:0]          wstrb_reg;
   // controller state
   vic_pkg::state_t     state_reg;
   logic [1:0]          cnt_reg;          // entry/return counter
   logic                reset_seen_reg;   // first cycle after reset
   // decode
   vic_pkg::reg_class_t wr_cls;
   vic_pkg::reg_class_t rd_cls;
   logic                do_write;
   logic [2:0]          wr_word;          // flag/enable word
   logic [4:0]          wr_pidx;          // priority register
   logic [31:0]         rd_data;
   // arbitration
   logic [3:0]          cpu_level;
   logic                irq_any;
   logic [6:0]          irq_best;
   logic [3:0]          best_prio;
   logic                trap_any;
   logic [2:0]          trap_best;
   logic [7:0]          sel_vec;
   logic                alt_active;
   logic [12:0]         last_page;
   logic [23:0]         table_base;
   logic [23:0]         entry_addr;
   int                  pidx;

   // classify a bus address into a register group
   function automatic vic_pkg::reg_class_t classify(
      input logic [11:0] a
   );
      classify = vic_pkg::CLS_NONE;
      if (a == vic_pkg::CTRL_OFFSET)
         classify = vic_pkg::CLS_CTRL;
      else if (a == vic_pkg::STATUS_OFFSET)
         classify = vic_pkg::CLS_STATUS;
      else if (a == vic_pkg::TRAP_OFFSET)
         classify = vic_pkg::CLS_TRAP;
      else if (a[11:5] == vic_pkg::FLAG_BASE[11:5])
         classify = vic_pkg::CLS_FLAG;
      else if (a[11:5] == vic_pkg::ENABLE_BASE[11:5])
         classify = vic_pkg::CLS_ENABLE;
      else if (a[11:7] == vic_pkg::PRIO_BASE[11:7])
         classify = vic_pkg::CLS_PRIO;
   endfunction

   // write decode from held address and data
   assign wr_cls   = classify(aw_addr_reg);
   assign rd_cls   = classify(araddr);
   assign do_write = !awready && !wready && !bvalid;
   assign wr_word  = aw_addr_reg[4:2];
   assign wr_pidx  = aw_addr_reg[6:2];

   // write address channel, held until the write is done
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready     <= 1'b1;
         aw_addr_reg <= 12'h000;
      end else if (awvalid && awready) begin
         awready     <= 1'b0;
         aw_addr_reg <= awaddr;
      end else if (do_write) begin
         awready     <= 1'b1;
      end
   end

   // write data channel, taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready    <= 1'b1;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
      end else if (wvalid && wready) begin
         wready    <= 1'b0;
         wdata_reg <= wdata;
         wstrb_reg <= wstrb;
      end else if (do_write) begin
         wready    <= 1'b1;
      end
   end

   // write response once both halves are in
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= vic_pkg::RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         // unmapped address answers slave error
         bresp  <= (wr_cls == vic_pkg::CLS_NONE) ?
                   vic_pkg::RESP_SLVERR : vic_pkg::RESP_OKAY;
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   // read data mux from the live read address
   always_comb begin
      rd_data = 32'h00000000;
      pidx    = 0;
      case (rd_cls)
         vic_pkg::CLS_CTRL:
            rd_data[vic_pkg::ALT_EN_BIT] = alt_table_enable_reg;
         vic_pkg::CLS_STATUS: begin
            rd_data[vic_pkg::STAT_VEC_LSB +: 8]   = cpu_vector;
            rd_data[vic_pkg::STAT_STATE_LSB +: 2] = state_reg;
            rd_data[vic_pkg::STAT_LEVEL_LSB +: 4] = cpu_level;
         end
         vic_pkg::CLS_TRAP:
            rd_data[5:0] = trap_flag_reg;
         vic_pkg::CLS_FLAG:
            rd_data[15:0] = flag_reg[{araddr[4:2], 4'h0} +: 16];
         vic_pkg::CLS_ENABLE:
            rd_data[15:0] = enable_reg[{araddr[4:2], 4'h0} +: 16];
         vic_pkg::CLS_PRIO: begin
            // four fields at 2:0, 6:4, 10:8, 14:12
            for (int j = 0; j < 4; j++) begin
               pidx = int'(araddr[6:2]) * 4 + j;
               rd_data[4*j +: 3] = prio_reg[3*pidx +: 3];
            end
         end
         default:
            rd_data = 32'h00000000;
      endcase
   end

   // read channel, one read under way at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h00000000;
         rresp   <= vic_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= rd_data;
         rresp   <= (rd_cls == vic_pkg::CLS_NONE) ?
                    vic_pkg::RESP_SLVERR : vic_pkg::RESP_OKAY;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   // alternate table enable bit in control word
   always_ff @(posedge aclk) begin
      if (!aresetn)
         alt_table_enable_reg <= 1'b0;
      else if (do_write && wr_cls == vic_pkg::CLS_CTRL && wstrb_reg[1])
         alt_table_enable_reg <= wdata_reg[vic_pkg::ALT_EN_BIT];
   end

   // sticky trap flags, write one to clear, a new trap wins
   always_ff @(posedge aclk) begin
      if (!aresetn)
         trap_flag_reg <= 6'h00;
      else begin
         for (int t = 0; t < vic_pkg::NUM_TRAP; t++) begin
            if (trap_req[t])
               trap_flag_reg[t] <= 1'b1;
            else if (do_write && wr_cls == vic_pkg::CLS_TRAP &&
                     wstrb_reg[0] && wdata_reg[t])
               trap_flag_reg[t] <= 1'b0;
         end
      end
   end

   // source flags, peripheral set beats a software write
   always_ff @(posedge aclk) begin
      if (!aresetn)
         flag_reg <= '0;
      else begin
         for (int i = 0; i < vic_pkg::NUM_IRQ; i++) begin
            // reserved positions never store anything
            if (vic_pkg::IMPL_MASK[i]) begin
               if (irq_set[i])
                  flag_reg[i] <= 1'b1;
               else if (do_write && wr_cls == vic_pkg::CLS_FLAG &&
                        wr_word == 3'(i / 16) &&
                        wstrb_reg[(i % 16) / 8])
                  flag_reg[i] <= wdata_reg[i % 16];
            end
         end
      end
   end

   // source enables at the same bit as their flags
   always_ff @(posedge aclk) begin
      if (!aresetn)
         enable_reg <= '0;
      else if (do_write && wr_cls == vic_pkg::CLS_ENABLE) begin
         for (int i = 0; i < vic_pkg::NUM_IRQ; i++) begin
            if (vic_pkg::IMPL_MASK[i] && wr_word == 3'(i / 16) &&
                wstrb_reg[(i % 16) / 8])
               enable_reg[i] <= wdata_reg[i % 16];
         end
      end
   end

   // priority fields, four per register
   always_ff @(posedge aclk) begin
      if (!aresetn)
         prio_reg <= '0;
      else if (do_write && wr_cls == vic_pkg::CLS_PRIO) begin
         for (int i = 0; i < vic_pkg::NUM_IRQ; i++) begin
            if (vic_pkg::IMPL_MASK[i] && wr_pidx == 5'(i / 4) &&
                wstrb_reg[(i % 4) / 2])
               prio_reg[3*i +: 3] <= wdata_reg[4*(i % 4) +: 3];
         end
      end
   end

   // effective cpu level, extension above status bits 7:5
   assign cpu_level = {priority_level_extension,
                       cpu_status_register[7:5]};

   // pick the highest priority source, lowest number on a tie
   always_comb begin
      irq_any   = 1'b0;
      irq_best  = 7'h00;
      best_prio = 4'h0;
      // descending scan with >= lets the lower number win
      for (int i = vic_pkg::NUM_IRQ - 1; i >= 0; i--) begin
         if (vic_pkg::IMPL_MASK[i] && flag_reg[i] && enable_reg[i] &&
             ({1'b0, prio_reg[3*i +: 3]} > cpu_level) &&
             ({1'b0, prio_reg[3*i +: 3]} >= best_prio)) begin
            irq_any   = 1'b1;
            irq_best  = 7'(i);
            best_prio = {1'b0, prio_reg[3*i +: 3]};
         end
      end
   end

   // traps are non-maskable and outrank every source
   always_comb begin
      trap_any  = 1'b0;
      trap_best = 3'h0;
      for (int t = vic_pkg::NUM_TRAP - 1; t >= 0; t--) begin
         if (trap_flag_reg[t]) begin
            trap_any  = 1'b1;
            trap_best = 3'(t);
         end
      end
   end

   // vector number and its table entry address
   assign sel_vec    = trap_any ? {5'h00, trap_best} :
                       ({1'b0, irq_best} + vic_pkg::VECTOR_OFFSET);
   assign alt_active = alt_table_enable_reg && alt_table_disable_fuse &&
                       (boot_segment_limit != 13'h0000);
   assign last_page  = boot_segment_limit - 13'h0001;
   assign table_base = alt_active ?
                       (24'(last_page) << vic_pkg::PAGE_SHIFT) :
                       vic_pkg::PRIMARY_BASE;
   assign entry_addr = table_base + {15'h0000, sel_vec, 1'b0};

   // entry and return sequencer, fixed cycle counts
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= vic_pkg::ST_IDLE;
         cnt_reg   <= 2'h0;
      end else begin
         case (state_reg)
            vic_pkg::ST_IDLE: begin
               cnt_reg <= 2'h0;
               if (trap_any || irq_any)
                  state_reg <= vic_pkg::ST_FETCH;
               else if (cpu_return)
                  state_reg <= vic_pkg::ST_RETURN;
            end
            vic_pkg::ST_FETCH: begin
               // same length whatever source was chosen
               if (cnt_reg == vic_pkg::FETCH_CYCLES - 2'h1) begin
                  state_reg <= vic_pkg::ST_PRESENT;
                  cnt_reg   <= 2'h0;
               end else
                  cnt_reg <= cnt_reg + 2'h1;
            end
            vic_pkg::ST_PRESENT: begin
               if (cpu_irq_ack)
                  state_reg <= vic_pkg::ST_IDLE;
            end
            vic_pkg::ST_RETURN: begin
               if (cnt_reg == vic_pkg::RETURN_CYCLES - 2'h1) begin
                  state_reg <= vic_pkg::ST_IDLE;
                  cnt_reg   <= 2'h0;
               end else
                  cnt_reg <= cnt_reg + 2'h1;
            end
            default: begin
               state_reg <= vic_pkg::ST_IDLE;
               cnt_reg   <= 2'h0;
            end
         endcase
      end
   end

   // program memory fetch of the chosen vector entry
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pm_rd          <= 1'b0;
         pm_addr        <= vic_pkg::RESET_ADDR;
         pm_boot_access <= 1'b0;
         cpu_vector     <= 8'h00;
      end else if (state_reg == vic_pkg::ST_IDLE &&
                   (trap_any || irq_any)) begin
         pm_rd          <= 1'b1;
         pm_addr        <= entry_addr;
         // both tables fetch under boot segment protection
         pm_boot_access <= 1'b1;
         cpu_vector     <= sel_vec;
      end else begin
         pm_rd          <= 1'b0;
         pm_boot_access <= 1'b0;
      end
   end

   // single request to the cpu with the fetched handler
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cpu_irq_req      <= 1'b0;
         cpu_handler_addr <= vic_pkg::RESET_ADDR;
      end else if (state_reg == vic_pkg::ST_FETCH &&
                   cnt_reg == vic_pkg::FETCH_CYCLES - 2'h1) begin
         cpu_irq_req      <= 1'b1;
         cpu_handler_addr <= pm_rdata;
      end else if (state_reg == vic_pkg::ST_PRESENT && cpu_irq_ack)
         cpu_irq_req      <= 1'b0;
   end

   // return done pulse at the end of the return count
   always_ff @(posedge aclk) begin
      if (!aresetn)
         cpu_ret_done <= 1'b0;
      else
         cpu_ret_done <= (state_reg == vic_pkg::ST_RETURN) &&
                         (cnt_reg == vic_pkg::RETURN_CYCLES - 2'h1);
   end

   // reset start pulse, the controller takes no part in it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reset_seen_reg  <= 1'b0;
         cpu_reset_start <= 1'b0;
      end else begin
         reset_seen_reg  <= 1'b1;
         cpu_reset_start <= !reset_seen_reg;
      end
   end

endmodule
`default_nettype wire

// [sim/vic_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module vic_checker (
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // vector fetch
   input wire logic        pm_rd,
   input wire logic [23:0] pm_addr,
   input wire logic        pm_boot_access,
   input wire logic [23:0] pm_rdata,
   // configuration
   input wire logic [12:0] boot_segment_limit,
   input wire logic        alt_table_disable_fuse,
   // cpu side
   input wire logic [7:0]  cpu_vector,
   input wire logic        cpu_irq_req,
   input wire logic        cpu_irq_ack,
   input wire logic [23:0] cpu_handler_addr,
   input wire logic        cpu_return,
   input wire logic        cpu_ret_done,
   input wire logic        cpu_reset_start
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // slot of the vector in the primary and in the alternate table
   wire logic [23:0] prim_slot = 24'h000004 + {15'h0, cpu_vector, 1'b0};
   wire logic [23:0] alt_slot  = {boot_segment_limit - 13'h0001, 11'h000}
                                 + {15'h0, cpu_vector, 1'b0};
   // one-cycle fetch strobe
   sequence fetch_s;
      pm_rd ##1 !pm_rd;
   endsequence
   entry_latency_a: assert property (fetch_s |=> cpu_irq_req)
      else $error("request not two cycles after fetch");
   handler_addr_a: assert property ($rose(cpu_irq_req) |->
      cpu_handler_addr == $past(pm_rdata))
      else $error("handler differs from fetched entry");
   boot_protect_a: assert property (pm_rd |-> pm_boot_access)
      else $error("fetch without boot protection");
   primary_slot_a: assert property (pm_rd && (!alt_table_disable_fuse
      || boot_segment_limit == 13'h0000) |-> pm_addr == prim_slot)
      else $error("primary slot address wrong");
   alt_slot_a: assert property (pm_rd && pm_addr != prim_slot
      |-> pm_addr == alt_slot)
      else $error("alternate slot address wrong");
   req_hold_a: assert property (cpu_irq_req && !cpu_irq_ack
      |=> cpu_irq_req)
      else $error("request dropped before acknowledge");
   req_drop_a: assert property (cpu_irq_req && cpu_irq_ack |=> !cpu_irq_req)
      else $error("request kept after acknowledge");
   return_latency_a: assert property ($rose(cpu_ret_done) |->
      $past(cpu_return, 4) ##1 !cpu_ret_done)
      else $error("return done at wrong time");
   reset_entry_a: assert property ($rose(aresetn) |=>
      cpu_reset_start && cpu_handler_addr == 24'h000000 ##1 !cpu_reset_start)
      else $error("reset start pulse wrong");
endmodule
bind vectored_interrupt_controller vic_checker vic_checker_inst (
   .aclk, .aresetn, .pm_rd, .pm_addr, .pm_boot_access, .pm_rdata,
   .boot_segment_limit, .alt_table_disable_fuse, .cpu_vector, .cpu_irq_req,
   .cpu_irq_ack, .cpu_handler_addr, .cpu_return, .cpu_ret_done,
   .cpu_reset_start);
`default_nettype wire

// [sim/cpu_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // bench controls
   input  wire logic [3:0]  base_level,
   input  wire logic [3:0]  ack_wait,
   // controller side
   input  wire logic        cpu_irq_req,
   input  wire logic        cpu_ret_done,
   output logic             cpu_irq_ack,
   output logic [7:0]       cpu_status_register,
   output logic             priority_level_extension,
   // program memory side
   input  wire logic        pm_rd,
   input  wire logic [23:0] pm_addr,
   output logic [23:0]      pm_rdata
);
   logic       in_service;  // top level while a handler runs
   logic [3:0] wait_cnt;    // cycles the request has waited
   // level bits in the status byte, extension bit on its own
   assign cpu_status_register      = in_service ? 8'hE0
                                     : {base_level[2:0], 5'h00};
   assign priority_level_extension = in_service | base_level[3];
   // slow or prompt acknowledge, service ends on return done
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cpu_irq_ack <= 1'b0;
         wait_cnt    <= 4'h0;
         in_service  <= 1'b0;
      end else begin
         cpu_irq_ack <= 1'b0;
         if (cpu_irq_req && !cpu_irq_ack && wait_cnt == ack_wait) begin
            cpu_irq_ack <= 1'b1;
            wait_cnt    <= 4'h0;
            in_service  <= 1'b1;
         end else if (cpu_irq_req && !cpu_irq_ack)
            wait_cnt <= wait_cnt + 4'h1;
         if (cpu_ret_done)
            in_service <= 1'b0;
      end
   end
   // every slot holds a handler address, stale data never lingers
   always_ff @(posedge aclk) begin
      if (!aresetn)
         pm_rdata <= 24'h000000;
      else if (pm_rd)
         pm_rdata <= {pm_addr[11:0], pm_addr[11:0]} ^ 24'h3C3C3C;
      else
         pm_rdata <= ~pm_rdata;
   end
endmodule
`default_nettype wire

// [sim/vectored_interrupt_controller_test.sv]
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_controller_test;
   logic         aclk = 1'b0, aresetn = 1'b0, cpu_return = 1'b0;
   logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic         arvalid = 1'b0, rready = 1'b0;
   logic         alt_table_disable_fuse = 1'b0;
   logic [11:0]  awaddr = 12'h000, araddr = 12'h000;
   logic [31:0]  wdata = 32'h0;
   logic [3:0]   wstrb = 4'hF, base_level = 4'h0, ack_wait = 4'h0;
   logic [127:0] irq_set = '0;
   logic [5:0]   trap_req = 6'h00;
   logic [12:0]  boot_segment_limit = 13'h0000;
   logic         awready, wready, bvalid, arready, rvalid;
   logic [1:0]   bresp, rresp, r;
   logic [31:0]  rdata, d;
   logic [7:0]   cpu_status_register, cpu_vector;
   logic         priority_level_extension, cpu_irq_ack, cpu_irq_req;
   logic         cpu_ret_done, cpu_reset_start, pm_rd, pm_boot_access;
   logic [23:0]  cpu_handler_addr, pm_addr, pm_rdata, cap_addr;
   int           errors = 0;
   int           checks_done = 0;
   int           src[6] = '{73, 90, 91, 101, 103, 110};
   vectored_interrupt_controller vectored_interrupt_controller_inst (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .irq_set, .trap_req,
      .boot_segment_limit, .alt_table_disable_fuse, .cpu_status_register,
      .priority_level_extension, .cpu_irq_ack, .cpu_return, .cpu_irq_req,
      .cpu_vector, .cpu_handler_addr, .cpu_ret_done, .cpu_reset_start,
      .pm_rd, .pm_addr, .pm_boot_access, .pm_rdata);
   cpu_core_model cpu_core_model_inst (
      .aclk, .aresetn, .base_level, .ack_wait, .cpu_irq_req, .cpu_ret_done,
      .cpu_irq_ack, .cpu_status_register, .priority_level_extension,
      .pm_rd, .pm_addr, .pm_rdata);
   // clock and fetch address capture
   always #5 aclk = ~aclk;
   always @(posedge aclk) if (pm_rd === 1'b1) cap_addr <= pm_addr;
   task automatic chk(input string what, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // write: address and data offered together, each released when taken
   task automatic wr(input logic [11:0] a, input logic [31:0] v,
                     output logic [1:0] resp);
      logic aw_d = 1'b0, w_d = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_d && w_d)) begin
         @(posedge aclk);
         aw_d |= (awready === 1'b1);
         w_d |= (wready === 1'b1);
         awvalid <= !aw_d;
         wvalid <= !w_d;
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] v,
                     output logic [1:0] resp);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      v = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   // one-cycle event on sources and traps
   task automatic raise(input logic [127:0] m, input logic [5:0] t);
      @(posedge aclk);
      irq_set <= m;
      trap_req <= t;
      @(posedge aclk);
      irq_set <= '0;
      trap_req <= 6'h00;
   endtask
   // check the entry, clear all flags, then return from the handler
   task automatic serve(input logic [7:0] v, input logic [23:0] a);
      int n;
      while (cpu_irq_req !== 1'b1) @(posedge aclk);
      chk("vector", cpu_vector, v);
      chk("fetch address", cap_addr, a);
      chk("handler", cpu_handler_addr, {a[11:0], a[11:0]} ^ 24'h3C3C3C);
      for (int k = 4; k < 8; k++) wr(vic_pkg::FLAG_BASE + 12'(4 * k), 0, r);
      wr(vic_pkg::TRAP_OFFSET, 32'h3F, r);
      repeat (20) @(posedge aclk);
      cpu_return <= 1'b1;
      @(posedge aclk);
      cpu_return <= 1'b0;
      for (n = 1; cpu_ret_done !== 1'b1; n++) @(posedge aclk);
      chk("return latency", n, 5);
   endtask
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("handler at reset", cpu_handler_addr, 0);
      rd(12'h0FC, d, r);
      chk("unmapped resp", r, vic_pkg::RESP_SLVERR);
      wr(12'h0FC, 0, r);
      chk("unmapped wr resp", r, vic_pkg::RESP_SLVERR);
      wr(vic_pkg::CTRL_OFFSET, 32'hFFFF, r);
      rd(vic_pkg::CTRL_OFFSET, d, r);
      chk("ctrl", d, 32'h100);
      wr(vic_pkg::CTRL_OFFSET, 0, r);
      wr(vic_pkg::PRIO_BASE + 12'h048, 32'hFFFF, r);
      rd(vic_pkg::PRIO_BASE + 12'h048, d, r);
      chk("prio 18", d, 32'h0070);
      wr(vic_pkg::FLAG_BASE + 12'h014, 32'hFFFF, r);
      rd(vic_pkg::FLAG_BASE + 12'h014, d, r);
      chk("flag 5", d, 32'hCC00);
      for (int k = 4; k < 8; k++) begin
         wr(vic_pkg::FLAG_BASE + 12'(4 * k), 0, r);
         wr(vic_pkg::ENABLE_BASE + 12'(4 * k), 32'hFFFF, r);
      end
      for (int i = 0; i < 6; i++) begin
         wr(vic_pkg::PRIO_BASE + 12'(src[i] & ~3),
            32'((i == 0 ? 3 : 1) << (4 * (src[i] % 4))), r);
         raise(128'h1 << src[i], 6'h00);
         serve(8'(src[i] + 8), 24'h4 + 24'(2 * (src[i] + 8)));
      end
      wr(vic_pkg::CTRL_OFFSET, 32'h100, r);
      for (int i = 0; i < 3; i++) begin
         alt_table_disable_fuse <= (i != 1);
         boot_segment_limit <= (i == 2) ? 13'h0000 : 13'h0003;
         raise(128'h1 << 73, 6'h00);
         serve(8'h51, (i == 0) ? 24'h0010A2 : 24'h0000A6);
      end
      wr(vic_pkg::PRIO_BASE + 12'h05C, 32'h2200, r);
      raise(128'h3 << 94, 6'h00);
      serve(8'h66, 24'h0000D0);
      wr(vic_pkg::PRIO_BASE + 12'h05C, 32'h5200, r);
      raise(128'h3 << 94, 6'h00);
      serve(8'h67, 24'h0000D2);
      base_level <= 4'h8;
      raise(128'h1 << 95, 6'h00);
      repeat (10) @(posedge aclk);
      chk("masked request", cpu_irq_req, 0);
      base_level <= 4'h4;
      serve(8'h67, 24'h0000D2);
      base_level <= 4'h0;
      ack_wait <= 4'h5;
      for (int t = 0; t < 6; t++) begin
         raise((t == 0) ? 128'h1 << 73 : '0, 6'(1 << t));
         serve(8'(t), 24'(4 + 2 * t));
      end
      stop_test();
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      stop_test();
   end
endmodule
`default_nettype wire
